//--- rtl/erac_defines.svh
// Offsets, field positions and reset values of the repeater control registers.
// Assumes 8-bit register addresses and 8-bit register data on a plain port.
`ifndef ERAC_DEFINES_SVH
`define ERAC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ERAC_OFF_KEY_DATA      8'hc9
`define ERAC_OFF_KEY_PTR_LO    8'hca
`define ERAC_OFF_KEY_PTR_HI    8'hcb
`define ERAC_OFF_PORT2_INFO    8'he2
`define ERAC_OFF_PORT3_INFO    8'he3
`define ERAC_OFF_XR_STATUS     8'he8
`define ERAC_OFF_XR_CONTROL    8'he9
`define ERAC_OFF_IRQ_STATUS    8'hec
`define ERAC_OFF_IRQ_MASK      8'hed

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ERAC_BIT_PRESENT       0
`define ERAC_BIT_KEY_WRITTEN   0
`define ERAC_BIT_RX_ENCRYPTED  1
`define ERAC_BIT_TAKEOVER      0
`define ERAC_BIT_LIST_READY    1
`define ERAC_BIT_HOTPLUG       2
`define ERAC_BIT_NO_INBAND     3
`define ERAC_BIT_EV_KEY        0
`define ERAC_BIT_EV_READY      1
`define ERAC_BIT_EV_ENCRYPT    2

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define ERAC_PTR_WIDTH         10
`define ERAC_MEM_DEPTH         1024
`define ERAC_IRQ_WIDTH         3
`define ERAC_RST_BYTE          8'h00
`define ERAC_RST_PTR           10'h000
`define ERAC_RST_IRQ           3'h0

`endif

//--- rtl/erac_key_list_mem.sv
// Single-port-write, single-port-read memory holding the downstream key list.
// Assumes one clock; read data appear one cycle after the address.
`timescale 1ns/1ps
`include "erac_defines.svh"
module erac_key_list_mem (
   input wire logic sys_clk,
   erac_mem_if.mem port
);
   // Storage, no reset: contents are only meaningful once written
   logic [7:0] store [0:`ERAC_MEM_DEPTH-1];

   // Byte write
   always_ff @(posedge sys_clk) begin
      if (port.wrEn) begin
         store[port.wrAddr] <= port.wrData;
      end
   end

   // Registered read for the digest engine
   always_ff @(posedge sys_clk) begin
      port.rdData <= store[port.rdAddr];
   end
endmodule : erac_key_list_mem

//--- rtl/erac_mem_if.sv
// Bundle between the control block and the key list memory.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface erac_mem_if;
   logic wrEn;                      // Store one byte
   erac_pkg::erac_ptr_type wrAddr;  // Byte address of the store
   logic [7:0] wrData;              // Byte stored
   erac_pkg::erac_ptr_type rdAddr;  // Byte address read by the digest engine
   logic [7:0] rdData;              // Registered read data

   modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
   modport mem (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface : erac_mem_if

//--- rtl/erac_pkg.sv
// Types shared by the repeater control block and its key list memory.
// Assumes the constants header is compiled alongside.
package erac_pkg;

   // Sequence of the list-ready handshake, one-hot
   typedef enum logic [2:0] {
      ERAC_SEQ_IDLE  = 3'b001,
      ERAC_SEQ_HASH  = 3'b010,
      ERAC_SEQ_READY = 3'b100
   } erac_seq_type;

   // Key list address
   typedef logic [9:0] erac_ptr_type;

endpackage : erac_pkg

//--- rtl/erac_repeater_ctl.sv
// Register bank for external control of the content-protection repeater path.
// Assumes a same-clock register master (no wait states) and a same-clock
// digest engine and receiver core that drive the status inputs.
//
// Function
// (R1) Port 2 address in bits 7..1, read-only
// (R2) Port 2 bit 0 reads port present
// (R3) Port 3 address in bits 7..1, read-only
// (R4) Port 3 bit 0 reads port present
// (R5) Status bit 1 shows encrypted video received
// (R6) Key-written flag sets on upstream key write
// (R7) Key-written flag clears when Ready raised
// (R8) Control bit 3 suppresses in-band controls
// (R9) Controller pulses hot-plug bit 2 briefly
// (R10) Controller sets list-ready after loading list
// (R11) List-ready starts digest, then raise Ready
// (R12) List-ready reads one only after digest
// (R13) New upstream key clears list-ready
// (R14) Control bit 0 hands over to controller
// (R15) Key list written bytewise through data port
// (R16) List pointer auto-increments after each byte
// (R17) Reset to zero, reserved bits read zero
`timescale 1ns/1ps
`include "erac_defines.svh"
module erac_repeater_ctl (
   input wire logic sys_clk,
   input wire logic rstn,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdData,
   // Downstream port reports from the repeater core
   input wire logic [6:0] txPortTwoAddressIn,
   input wire logic txPortTwoPresentIn,
   input wire logic [6:0] txPortThreeAddressIn,
   input wire logic txPortThreePresentIn,
   // Upstream link events
   input wire logic rxEncryptedIn,
   input wire logic upstreamKeyWrite,
   // Digest engine handshake
   output logic digestStart,
   input wire logic digestDone,
   output logic [9:0] keyListLength,
   input wire logic [9:0] digestReadAddr,
   output logic [7:0] digestReadData,
   // Control outputs
   output logic upstreamReady,
   output logic externalControllerTakeover,
   output logic downstreamHotplugPulse,
   output logic suppressInbandControls,
   output logic irq
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   erac_mem_if memBus ();                 // Link to the key list memory
   erac_pkg::erac_seq_type seqState;      // Handshake state
   erac_pkg::erac_seq_type next_seqState; // Handshake state, next
   logic [6:0] txPortTwoAddress;          // Captured port 2 address
   logic txPortTwoPresent;                // Captured port 2 present
   logic [6:0] txPortThreeAddress;        // Captured port 3 address
   logic txPortThreePresent;              // Captured port 3 present
   logic rxEncrypted;                     // Captured encryption state
   logic upstreamKeyWrittenFlag;          // Sticky key-written flag
   logic keyListReady;                    // Readback of the list-ready bit
   erac_pkg::erac_ptr_type keyListWritePointer; // Next byte address
   logic [`ERAC_IRQ_WIDTH-1:0] irqStatus; // Sticky event bits
   logic [`ERAC_IRQ_WIDTH-1:0] irqMask;   // Event enables
   logic [`ERAC_IRQ_WIDTH-1:0] irqEvents; // Events this cycle
   logic readyRise;                       // Ready is raised this cycle
   logic ctlWrite;                        // Write to the control register
   logic startHash;                       // List-ready accepted this cycle

   // Strobe decode used by more than one process
   function automatic logic hitWrite(input logic [7:0] addr, input logic [7:0] off,
                                     input logic wr);
      hitWrite = wr && (addr == off);
   endfunction : hitWrite

   assign ctlWrite = hitWrite(regAddr, `ERAC_OFF_XR_CONTROL, regWrite);

   // ----------------------------------------------------------------------
   // Status capture
   // ----------------------------------------------------------------------

   // Port reports are same-clock core signals, so a plain capture suffices
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         // (R17) zero after reset
         txPortTwoAddress <= 7'h00;
         txPortTwoPresent <= 1'b0;
         txPortThreeAddress <= 7'h00;
         txPortThreePresent <= 1'b0;
      end else begin
         // (R1) port two address
         txPortTwoAddress <= txPortTwoAddressIn;
         // (R2) port two present
         txPortTwoPresent <= txPortTwoPresentIn;
         // (R3) port three address
         txPortThreeAddress <= txPortThreeAddressIn;
         // (R4) port three present
         txPortThreePresent <= txPortThreePresentIn;
      end
   end

   // Encryption state of the incoming video
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rxEncrypted <= 1'b0;
      end else begin
         // (R5) encrypted video status
         rxEncrypted <= rxEncryptedIn;
      end
   end

   // ----------------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------------

   // Writable control bits; the list-ready bit lives in the sequencer
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         externalControllerTakeover <= 1'b0;
         downstreamHotplugPulse <= 1'b0;
         suppressInbandControls <= 1'b0;
      end else if (ctlWrite) begin
         // (R14) external takeover bit
         externalControllerTakeover <= regWrData[`ERAC_BIT_TAKEOVER];
         // (R9) hot-plug held as written; pulse width is the controller's job
         downstreamHotplugPulse <= regWrData[`ERAC_BIT_HOTPLUG];
         // (R8) in-band control suppression
         suppressInbandControls <= regWrData[`ERAC_BIT_NO_INBAND];
      end
   end

   // ----------------------------------------------------------------------
   // List-ready sequencer
   // ----------------------------------------------------------------------

   // A request counts only with takeover set, taking the value of the same
   // write, so one write may enable takeover and raise list-ready at once
   // (R10) request trusted as list loaded
   assign startHash = (seqState == erac_pkg::ERAC_SEQ_IDLE) && ctlWrite
                      && regWrData[`ERAC_BIT_LIST_READY] && regWrData[`ERAC_BIT_TAKEOVER]
                      && !upstreamKeyWrite;

   // Next state; a new upstream key always wins and returns the handshake to idle
   always_comb begin
      next_seqState = seqState;
      if (upstreamKeyWrite) begin
         // (R13) new key clears list-ready
         next_seqState = erac_pkg::ERAC_SEQ_IDLE;
      end else if (!externalControllerTakeover && !startHash) begin
         // Internal controller owns the handshake
         next_seqState = erac_pkg::ERAC_SEQ_IDLE;
      end else begin
         unique case (seqState)
            erac_pkg::ERAC_SEQ_IDLE: begin
               // (R11) list-ready starts digest
               if (startHash) begin
                  next_seqState = erac_pkg::ERAC_SEQ_HASH;
               end
            end
            erac_pkg::ERAC_SEQ_HASH: begin
               // Writing zero abandons the request
               if (ctlWrite && !regWrData[`ERAC_BIT_LIST_READY]) begin
                  next_seqState = erac_pkg::ERAC_SEQ_IDLE;
               end else if (digestDone) begin
                  // (R11) digest done raises Ready
                  next_seqState = erac_pkg::ERAC_SEQ_READY;
               end
            end
            erac_pkg::ERAC_SEQ_READY: begin
               if (ctlWrite && !regWrData[`ERAC_BIT_LIST_READY]) begin
                  next_seqState = erac_pkg::ERAC_SEQ_IDLE;
               end
            end
            default: begin
               // Illegal one-hot code recovers to idle
               next_seqState = erac_pkg::ERAC_SEQ_IDLE;
            end
         endcase
      end
   end

   assign readyRise = (next_seqState == erac_pkg::ERAC_SEQ_READY)
                      && (seqState != erac_pkg::ERAC_SEQ_READY);

   // State, Ready output and the digest start pulse
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         seqState <= erac_pkg::ERAC_SEQ_IDLE;
         upstreamReady <= 1'b0;
         digestStart <= 1'b0;
         keyListReady <= 1'b0;
      end else begin
         seqState <= next_seqState;
         upstreamReady <= (next_seqState == erac_pkg::ERAC_SEQ_READY);
         digestStart <= startHash;
         // (R12) readback only after digest
         keyListReady <= (next_seqState == erac_pkg::ERAC_SEQ_READY);
      end
   end

   // Key-written flag; a key write in the cycle Ready rises keeps it set
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         upstreamKeyWrittenFlag <= 1'b0;
      end else if (upstreamKeyWrite) begin
         // (R6) set on upstream key write
         upstreamKeyWrittenFlag <= 1'b1;
      end else if (readyRise) begin
         // (R7) clear when Ready raised
         upstreamKeyWrittenFlag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Key list write path
   // ----------------------------------------------------------------------

   // Pointer: loaded through its two bytes, stepped by each data write.
   // It wraps at the memory depth rather than saturating, so an overlong
   // list overwrites its start; the controller must keep within depth.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         keyListWritePointer <= `ERAC_RST_PTR;
      end else if (hitWrite(regAddr, `ERAC_OFF_KEY_PTR_LO, regWrite)) begin
         keyListWritePointer <= {keyListWritePointer[9:8], regWrData};
      end else if (hitWrite(regAddr, `ERAC_OFF_KEY_PTR_HI, regWrite)) begin
         keyListWritePointer <= {regWrData[1:0], keyListWritePointer[7:0]};
      end else if (hitWrite(regAddr, `ERAC_OFF_KEY_DATA, regWrite)) begin
         // (R16) step after each byte
         keyListWritePointer <= keyListWritePointer + 10'h001;
      end
   end

   // (R15) one byte per data write
   assign memBus.wrEn = hitWrite(regAddr, `ERAC_OFF_KEY_DATA, regWrite);
   assign memBus.wrAddr = keyListWritePointer;
   assign memBus.wrData = regWrData;
   assign memBus.rdAddr = digestReadAddr;
   assign digestReadData = memBus.rdData;

   // Length seen by the digest engine tracks the pointer
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         keyListLength <= `ERAC_RST_PTR;
      end else begin
         keyListLength <= keyListWritePointer;
      end
   end

   erac_key_list_mem keyMem (
      .sys_clk(sys_clk),
      .port(memBus.mem)
   );

   // ----------------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------------

   // Events: upstream key write, Ready raised, encryption state change
   assign irqEvents = {(rxEncryptedIn != rxEncrypted), readyRise, upstreamKeyWrite};

   // Write-one-to-clear; an event in the clearing cycle survives
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irqStatus <= `ERAC_RST_IRQ;
      end else if (hitWrite(regAddr, `ERAC_OFF_IRQ_STATUS, regWrite)) begin
         irqStatus <= (irqStatus & ~regWrData[`ERAC_IRQ_WIDTH-1:0]) | irqEvents;
      end else begin
         irqStatus <= irqStatus | irqEvents;
      end
   end

   // Mask register
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irqMask <= `ERAC_RST_IRQ;
      end else if (hitWrite(regAddr, `ERAC_OFF_IRQ_MASK, regWrite)) begin
         irqMask <= regWrData[`ERAC_IRQ_WIDTH-1:0];
      end
   end

   // Registered level output, one cycle behind the status bits
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStatus & irqMask);
      end
   end

   // ----------------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------------

   // Data stand only in the cycle after the strobe; zero otherwise
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         regRdData <= `ERAC_RST_BYTE;
      end else if (!regRead) begin
         regRdData <= 8'h00;
      end else begin
         // (R17) reserved and unmapped read zero
         unique case (regAddr)
            `ERAC_OFF_PORT2_INFO: begin
               // (R1) address above present bit
               regRdData <= {txPortTwoAddress, txPortTwoPresent};
            end
            `ERAC_OFF_PORT3_INFO: begin
               // (R3) address above present bit
               regRdData <= {txPortThreeAddress, txPortThreePresent};
            end
            `ERAC_OFF_XR_STATUS: begin
               regRdData <= {6'h00, rxEncrypted, upstreamKeyWrittenFlag};
            end
            `ERAC_OFF_XR_CONTROL: begin
               regRdData <= {4'h0, suppressInbandControls, downstreamHotplugPulse,
                             keyListReady, externalControllerTakeover};
            end
            `ERAC_OFF_KEY_PTR_LO: begin
               regRdData <= keyListWritePointer[7:0];
            end
            `ERAC_OFF_KEY_PTR_HI: begin
               regRdData <= {6'h00, keyListWritePointer[9:8]};
            end
            `ERAC_OFF_IRQ_STATUS: begin
               regRdData <= {5'h00, irqStatus};
            end
            `ERAC_OFF_IRQ_MASK: begin
               regRdData <= {5'h00, irqMask};
            end
            default: begin
               // Data port is write-only; unmapped offsets read zero
               regRdData <= 8'h00;
            end
         endcase
      end
   end

endmodule : erac_repeater_ctl

//--- test/erac_digest_model.sv
// Behavioural digest engine answering the block's start pulse.
// Assumes the same clock; the bench sets the answer delay.
`timescale 1ns/1ps
module erac_digest_model (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic digestStart,
   input wire logic [7:0] delayCycles,
   output logic digestDone
);
   logic [7:0] count; // Cycles left until done, zero when idle

   // ----------------------------------------------------------------------
   // Answer timing
   // ----------------------------------------------------------------------
   // done after digest
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         count <= 8'h00;
         digestDone <= 1'b0;
      end else begin
         digestDone <= (count == 8'h01);
         if (digestStart) begin
            count <= delayCycles; // Zero here would never answer
         end else if (count != 8'h00) begin
            count <= count - 8'h01;
         end
      end
   end
endmodule : erac_digest_model

//--- test/erac_repeater_ctl_checker.sv
// Port checks of the repeater control register block.
// Assumes it is bound to erac_repeater_ctl and sees only its ports.
`timescale 1ns/1ps
module erac_repeater_ctl_checker (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regRdData,
   input wire logic [6:0] txPortTwoAddressIn,
   input wire logic txPortTwoPresentIn,
   input wire logic rxEncryptedIn,
   input wire logic upstreamKeyWrite,
   input wire logic digestStart,
   input wire logic digestDone,
   input wire logic upstreamReady,
   input wire logic externalControllerTakeover,
   input wire logic downstreamHotplugPulse,
   input wire logic suppressInbandControls,
   input wire logic irq
);
   // One clock domain
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   // ----------------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------------
   AST_RD_IDLE: assert property (!$past(regRead) |-> regRdData == 8'h00)
      else $error("read data not zero");
   // Stable inputs only: the report is captured a cycle late
   AST_PORT2_RD: assert property (regRead && regAddr == 8'he2 && $stable(txPortTwoAddressIn)
      && $stable(txPortTwoPresentIn) |=>
      regRdData == {$past(txPortTwoAddressIn), $past(txPortTwoPresentIn)})
      else $error("port two read wrong");
   AST_STATUS_RD: assert property (regRead && regAddr == 8'he8 && $stable(rxEncryptedIn)
      |=> regRdData[7:1] == {6'h00, $past(rxEncryptedIn)})
      else $error("status read wrong");
   AST_CTRL_OUT: assert property (regWrite && regAddr == 8'he9 |=>
      {4'h0, suppressInbandControls, downstreamHotplugPulse, 1'b0, externalControllerTakeover}
      == ($past(regWrData) & 8'h0d))
      else $error("control outputs wrong");
   AST_KEY_FLAG: assert property (upstreamKeyWrite ##1 (regRead && regAddr == 8'he8)
      |=> regRdData[0])
      else $error("key flag not set");

   // ----------------------------------------------------------------------
   // List-ready sequence
   // ----------------------------------------------------------------------
   AST_START_PULSE: assert property (digestStart |=> !digestStart)
      else $error("start pulse too long");
   AST_START_CAUSE: assert property (digestStart |-> $past(regWrite) &&
      $past(regAddr) == 8'he9 && ($past(regWrData) & 8'h03) == 8'h03)
      else $error("start without request");
   AST_READY_CAUSE: assert property ($rose(upstreamReady) |-> $past(digestDone))
      else $error("ready without done");
   AST_LIST_RD: assert property (regRead && regAddr == 8'he9 |=>
      regRdData[1] == $past(upstreamReady))
      else $error("list ready readback wrong");
   AST_KEY_DROP: assert property (upstreamKeyWrite |=> !upstreamReady)
      else $error("ready kept after new key");

   // Main scenarios reached
   COV_START: cover property (digestStart);
   COV_READY: cover property ($rose(upstreamReady));
   COV_IRQ: cover property ($rose(irq));
endmodule : erac_repeater_ctl_checker

bind erac_repeater_ctl erac_repeater_ctl_checker u_checker (.sys_clk, .rstn, .regAddr,
   .regWrData, .regWrite, .regRead, .regRdData, .txPortTwoAddressIn, .txPortTwoPresentIn,
   .rxEncryptedIn, .upstreamKeyWrite, .digestStart, .digestDone, .upstreamReady,
   .externalControllerTakeover, .downstreamHotplugPulse, .suppressInbandControls, .irq);

//--- test/testbench.sv
// Self-checking bench for the repeater control register block.
// Assumes the digest model answers after a set delay.
`timescale 1ns/1ps
module testbench;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic regWrite = 1'b0, regRead = 1'b0;
   logic [6:0] p2Addr = 7'h00;
   logic [6:0] p3Addr = 7'h00;
   logic p2Present = 1'b0, p3Present = 1'b0, rxEnc = 1'b0, keyWrite = 1'b0;
   logic [9:0] peekAddr = 10'h000; // Digest side read address
   logic [7:0] delay = 8'h14; // Digest model answer delay
   logic [7:0] regRdData, peekData, rdv;
   logic [9:0] listLen;
   logic digestStart, digestDone, upstreamReady, takeover, hotplug, noInband, irq;
   int num_errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   typedef struct packed {logic [7:0] a; logic [6:0] p; logic v; logic e; logic [7:0] x;}
      erac_row_type;
   // Offset, port report, present, encrypted, expected read
   erac_row_type rows [8] = '{'{8'he2, 7'h55, 1'b1, 1'b0, 8'hab},
      '{8'he3, 7'h55, 1'b1, 1'b0, 8'h54}, '{8'he2, 7'h00, 1'b0, 1'b1, 8'h00},
      '{8'he3, 7'h00, 1'b0, 1'b1, 8'hff}, '{8'he8, 7'h00, 1'b0, 1'b1, 8'h02},
      '{8'he8, 7'h00, 1'b0, 1'b0, 8'h00}, '{8'h51, 7'h00, 1'b0, 1'b0, 8'h00},
      '{8'hc9, 7'h00, 1'b0, 1'b0, 8'h00}};
   logic [7:0] offs [4] = '{8'he2, 8'he3, 8'he8, 8'he9};
   logic [7:0] keys [3] = '{8'ha1, 8'hb2, 8'hc3};

   always #2.5 sys_clk = ~sys_clk; // 200 MHz

   erac_repeater_ctl u_dut (.sys_clk, .rstn, .regAddr, .regWrData, .regWrite, .regRead,
      .regRdData, .txPortTwoAddressIn(p2Addr), .txPortTwoPresentIn(p2Present),
      .txPortThreeAddressIn(p3Addr), .txPortThreePresentIn(p3Present),
      .rxEncryptedIn(rxEnc), .upstreamKeyWrite(keyWrite), .digestStart, .digestDone,
      .keyListLength(listLen), .digestReadAddr(peekAddr), .digestReadData(peekData),
      .upstreamReady, .externalControllerTakeover(takeover),
      .downstreamHotplugPulse(hotplug), .suppressInbandControls(noInband), .irq);

   erac_digest_model u_digest (.sys_clk, .rstn, .digestStart, .delayCycles(delay),
      .digestDone);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   task automatic final_report();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report

   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // n edges, then off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   // One-cycle write, ending off the edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge sys_clk);
      regWrite <= 1'b0;
      #1;
   endtask : wr

   // One-cycle read, data taken a cycle later
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge sys_clk);
      regRead <= 1'b0;
      #1;
      d = regRdData;
   endtask : rd

   task automatic pulseKey();
      keyWrite <= 1'b1;
      tick(1);
      keyWrite <= 1'b0;
   endtask : pulseKey

   task automatic waitReady();
      for (int i = 0; i < 100 && upstreamReady !== 1'b1; i++) tick(1);
   endtask : waitReady

   // Hang guard, well above the run's length
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         final_report();
      end
   end

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (5) @(posedge sys_clk);
      rstn <= 1'b1;
      #1;
      chk({takeover, hotplug, noInband, upstreamReady, irq}, 5'h00);
      foreach (offs[i]) begin
         rd(offs[i], rdv);
         chk(rdv, 8'h00);
      end
      // Ordinary reads from the table
      foreach (rows[i]) begin
         p2Addr <= rows[i].p;
         p2Present <= rows[i].v;
         p3Addr <= rows[i].p ^ 7'h7f;
         p3Present <= ~rows[i].v;
         rxEnc <= rows[i].e;
         tick(2);
         rd(rows[i].a, rdv);
         chk(rdv, rows[i].x);
      end
      // Control bits, reserved ones written high
      wr(8'he9, 8'hfd);
      rd(8'he9, rdv);
      chk(rdv, 8'h0d);
      chk({noInband, hotplug, takeover}, 3'h7);
      wr(8'he9, 8'h01);
      chk({noInband, hotplug, takeover}, 3'h1);
      // List ready refused without takeover
      wr(8'he9, 8'h00);
      wr(8'he9, 8'h02);
      chk(digestStart, 1'b0);
      rd(8'he9, rdv);
      chk(rdv, 8'h00);
      wr(8'he9, 8'h01);
      // Upstream key, then list loaded from zero
      pulseKey();
      rd(8'he8, rdv);
      chk(rdv, 8'h01);
      wr(8'hca, 8'h00);
      wr(8'hcb, 8'h00);
      foreach (keys[i]) wr(8'hc9, keys[i]);
      rd(8'hca, rdv);
      chk(rdv, 8'h03);
      chk(listLen, 10'h003);
      peekAddr <= 10'h001;
      tick(2);
      chk(peekData, 8'hb2);
      // Slow digest: list ready reads 0 until done
      wr(8'he9, 8'h03);
      chk(digestStart, 1'b1);
      rd(8'he9, rdv);
      chk(rdv, 8'h01);
      waitReady();
      chk(upstreamReady, 1'b1);
      rd(8'he9, rdv);
      chk(rdv, 8'h03);
      rd(8'he8, rdv);
      chk(rdv, 8'h00);
      // Interrupt raised, masked, cleared
      wr(8'hed, 8'h02);
      tick(2);
      chk(irq, 1'b1);
      wr(8'hed, 8'h00);
      tick(2);
      chk(irq, 1'b0);
      rd(8'hec, rdv);
      chk(rdv, 8'h07);
      wr(8'hed, 8'h02);
      wr(8'hec, 8'h07);
      tick(2);
      chk(irq, 1'b0);
      // New key while ready drops list ready
      pulseKey();
      chk(upstreamReady, 1'b0);
      rd(8'he9, rdv);
      chk(rdv, 8'h01);
      rd(8'he8, rdv);
      chk(rdv, 8'h01);
      // Fast digest, then cancel
      delay <= 8'h01;
      wr(8'he9, 8'h03);
      waitReady();
      chk(upstreamReady, 1'b1);
      wr(8'he9, 8'h01);
      chk(upstreamReady, 1'b0);
      // Reset in mid-run
      rstn <= 1'b0;
      tick(2);
      chk({takeover, upstreamReady, irq}, 3'h0);
      rstn <= 1'b1;
      tick(1);
      rd(8'he9, rdv);
      chk(rdv, 8'h00);
      final_report();
   end
endmodule : testbench
